// *** core/ped_pkg.sv ***
// package: constants, carriers and summary for the pin edge detection unit
// What this block does
// - seven pins, each rising or falling, forwarded
// - low register pins 0-3, high 4-6
// - both edge-select registers reset to zero
// - whole-byte and single-bit register writes
// - high register picks slot four source
// - baud clock pin detects both edges
// - detection stops in stop, pin zero excepted
// - pins one-six sampled every four clocks
// - three identical samples accept a level
// - filtered edge reported twelve-fifteen clocks later
// - edge during polarity change may go either
// - edges routed to irqs, captures, triggers, starts
// - raw pin levels readable, filter bypassed
package ped_pkg;

  localparam int NUM_PINS       = 7;
  localparam int LOW_PINS       = 4;
  localparam int BAUD_PIN       = 5;
  localparam int SLOT4_SEL_BIT  = 3;
  localparam int CLK_PERIOD_NS  = 25;
  localparam int PIN0_FILT_US   = 10;
  localparam int PIN0_HOLD_CYCLES = (PIN0_FILT_US * 1000) / CLK_PERIOD_NS < 1 ? 1 :
                                    (PIN0_FILT_US * 1000) / CLK_PERIOD_NS;
  localparam int TICK_DIV       = 4;
  localparam int FILT_SAMPLES   = 3;
  localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] SEL_MASK  = 8'h0F;

  typedef struct packed {
    logic       sel_high;
    logic       byte_wr;
    logic       bit_wr;
    logic [2:0] bit_idx;
    logic       bit_val;
    logic [7:0] wr_data;
  } ped_reg_req_t;

  typedef struct packed {
    logic nmi;
    logic standby_wake;
    logic ext_irq_zero;
    logic timer1_capture;
    logic rto_trigger;
    logic ext_irq_one;
    logic timer2_capture;
    logic ext_irq_two;
    logic timer2_count_clock;
    logic ext_irq_three;
    logic timer16_capture;
    logic ext_irq_four;
    logic uart_baud_clock;
    logic ext_irq_five;
    logic adc_start;
    logic irq_slot_four;
  } ped_events_t;

endpackage

// *** core/ped_dfilt.sv ***
// digital noise filter: accepts a level after identical samples on a tick
`timescale 1ns/1ps
module ped_dfilt #(
  parameter int SAMPLES = ped_pkg::FILT_SAMPLES
) (
  input  logic clk_sys_in,
  input  logic sys_rst_in,
  input  logic tick_in,
  input  logic level_in,
  output logic lvl_out,
  output logic vld_out
);

  generate
    if (SAMPLES < 2)
    begin : g_bad
      $error("ped_dfilt needs at least two samples");
    end
  endgenerate

  typedef struct packed {
    logic [SAMPLES-1:0] smp;
    logic               lvl;
    logic               vld;
  } ped_dfilt_state_t;

  ped_dfilt_state_t s_reg;
  ped_dfilt_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (tick_in)
    begin
      s_next.smp = {s_reg.smp[SAMPLES-2:0], level_in};
      if ((&s_next.smp) || !(|s_next.smp))
      begin
        s_next.lvl = s_next.smp[0];
        s_next.vld = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign lvl_out = s_reg.lvl;
  assign vld_out = s_reg.vld;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence level_held;
    $changed(level_in) ##1 ($stable(level_in))[*8] ##1 ($stable(level_in))[*4];
  endsequence

  three_same_a: assert property ($changed(lvl_out) |-> $past(tick_in) &&
    $past(level_in) == lvl_out && $past(s_reg.smp[SAMPLES-2:0]) == {(SAMPLES-1){lvl_out}})
    else $error("level accepted without identical samples");

  latency_max_a: assert property (level_held |-> lvl_out == level_in)
    else $error("held level not accepted within twelve clocks");

endmodule

// *** core/ped_adelay.sv ***
// delay filter for pin zero: level must persist for the hold time
`timescale 1ns/1ps
module ped_adelay #(
  parameter int HOLD_CYCLES = ped_pkg::PIN0_HOLD_CYCLES
) (
  input  logic clk_sys_in,
  input  logic sys_rst_in,
  input  logic level_in,
  output logic lvl_out,
  output logic vld_out
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(HOLD_CYCLES - 1);

  generate
    if (HOLD_CYCLES < 1)
    begin : g_bad
      $error("ped_adelay needs a hold of at least one cycle");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lvl;
    logic          vld;
  } ped_adelay_state_t;

  ped_adelay_state_t s_reg;
  ped_adelay_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (s_reg.vld && level_in == s_reg.lvl)
      s_next.cnt = '0;
    else if (s_reg.cnt == CNT_LAST)
    begin
      s_next.cnt = '0;
      s_next.lvl = level_in;
      s_next.vld = 1'b1;
    end
    else
      s_next.cnt = s_reg.cnt + CW'(1);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign lvl_out = s_reg.lvl;
  assign vld_out = s_reg.vld;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  hold_count_a: assert property ($changed(lvl_out) |-> $past(s_reg.cnt) == CNT_LAST)
    else $error("pin zero level accepted before hold time");

  short_reject_a: assert property ((s_reg.vld && level_in == lvl_out) |=> s_reg.cnt == '0)
    else $error("pin zero hold count not restarted");

endmodule

// *** core/ped_top.sv ***
// top of the pin edge detection unit: sync, select registers, edge routing
`timescale 1ns/1ps
module ped_top (
  input  logic                 clk_sys_in,
  input  logic                 sys_rst_in,
  input  logic [6:0]           edge_pins_in,
  input  logic                 stop_mode_in,
  input  logic                 baud_mode_in,
  input  logic                 timer3_match_irq_in,
  input  ped_pkg::ped_reg_req_t reg_req_in,
  output logic [7:0]           edge_select_low_out,
  output logic [7:0]           edge_select_high_out,
  output logic [6:0]           raw_pins_out,
  output ped_pkg::ped_events_t events_out
);

  typedef struct packed {
    logic [7:0]           edge_select_reg_low;
    logic [7:0]           edge_select_reg_high;
    logic [6:0]           sync_a;
    logic [6:0]           sync_b;
    logic [1:0]           div;
    logic [6:0]           lvl_prev;
    logic [6:0]           vld_prev;
    ped_pkg::ped_events_t ev;
  } ped_top_state_t;

  ped_top_state_t s_reg;
  ped_top_state_t s_next;

  logic       tick;
  logic [6:0] lvl;
  logic [6:0] vld;

  // byte write wins over a bit write in the same cycle
  function automatic logic [7:0] reg_update(
    input logic [7:0]            old,
    input ped_pkg::ped_reg_req_t req,
    input logic                  high
  );
    logic [7:0] v;
    v = old;
    if (req.sel_high == high)
    begin
      if (req.byte_wr)
        v = req.wr_data;
      else if (req.bit_wr)
        v[req.bit_idx] = req.bit_val;
    end
    return v & ped_pkg::SEL_MASK;
  endfunction

  // polarity bit of a pin: low register for pins 0-3, high for 4-6
  function automatic logic pin_pol(
    input logic [7:0] lo,
    input logic [7:0] hi,
    input int         idx
  );
    logic p;
    if (idx < ped_pkg::LOW_PINS)
      p = lo[idx];
    else
      p = hi[idx - ped_pkg::LOW_PINS];
    return p;
  endfunction

  function automatic logic sel_edge(
    input logic rise,
    input logic fall,
    input logic pol
  );
    return pol ? rise : fall;
  endfunction

  assign tick = (s_reg.div == ped_pkg::TICK_LAST);

  ped_adelay #(
    .HOLD_CYCLES (ped_pkg::PIN0_HOLD_CYCLES)
  ) u_pin0 (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (s_reg.sync_b[0]),
    .lvl_out    (lvl[0]),
    .vld_out    (vld[0])
  );

  genvar g;
  generate
    for (g = 1; g < ped_pkg::NUM_PINS; g++)
    begin : g_filt
      ped_dfilt #(
        .SAMPLES (ped_pkg::FILT_SAMPLES)
      ) u_filt (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .tick_in    (tick),
        .level_in   (s_reg.sync_b[g]),
        .lvl_out    (lvl[g]),
        .vld_out    (vld[g])
      );
    end
  endgenerate

  always_comb
  begin
    logic [6:0] rise;
    logic [6:0] fall;
    logic [6:0] det;
    logic [6:0] act;
    logic       baud_any;
    rise = '0;
    fall = '0;
    det = '0;
    act = '0;
    baud_any = 1'b0;
    s_next = s_reg;
    s_next.sync_a = edge_pins_in;
    s_next.sync_b = s_reg.sync_a;
    s_next.div = tick ? 2'h0 : s_reg.div + 2'h1;
    s_next.edge_select_reg_low = reg_update(s_reg.edge_select_reg_low, reg_req_in, 1'b0);
    s_next.edge_select_reg_high = reg_update(s_reg.edge_select_reg_high, reg_req_in, 1'b1);
    s_next.lvl_prev = lvl;
    s_next.vld_prev = vld;
    for (int i = 0; i < ped_pkg::NUM_PINS; i++)
    begin
      rise[i] = vld[i] && s_reg.vld_prev[i] && lvl[i] && !s_reg.lvl_prev[i];
      fall[i] = vld[i] && s_reg.vld_prev[i] && !lvl[i] && s_reg.lvl_prev[i];
      // polarity is read live, so an edge during a change may go either way
      det[i] = sel_edge(rise[i], fall[i],
                        pin_pol(s_reg.edge_select_reg_low, s_reg.edge_select_reg_high, i));
      act[i] = det[i] && (i == 0 || !stop_mode_in);
    end
    baud_any = baud_mode_in && !stop_mode_in &&
               (rise[ped_pkg::BAUD_PIN] || fall[ped_pkg::BAUD_PIN]);
    s_next.ev.nmi = act[0];
    s_next.ev.standby_wake = act[0];
    s_next.ev.ext_irq_zero = act[1];
    s_next.ev.timer1_capture = act[1];
    s_next.ev.rto_trigger = act[1];
    s_next.ev.ext_irq_one = act[2];
    s_next.ev.timer2_capture = act[2];
    s_next.ev.ext_irq_two = act[3];
    s_next.ev.timer2_count_clock = act[3];
    s_next.ev.ext_irq_three = act[4];
    s_next.ev.timer16_capture = act[4];
    s_next.ev.ext_irq_four = act[5];
    s_next.ev.uart_baud_clock = baud_any;
    s_next.ev.ext_irq_five = act[6];
    s_next.ev.adc_start = act[6];
    s_next.ev.irq_slot_four = s_reg.edge_select_reg_high[ped_pkg::SLOT4_SEL_BIT] ?
                              timer3_match_irq_in : act[5];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      s_reg <= '0;
      s_reg.edge_select_reg_low <= ped_pkg::SEL_RESET;
      s_reg.edge_select_reg_high <= ped_pkg::SEL_RESET;
    end
    else
      s_reg <= s_next;
  end

  assign edge_select_low_out = s_reg.edge_select_reg_low;
  assign edge_select_high_out = s_reg.edge_select_reg_high;
  assign raw_pins_out = s_reg.sync_b;
  assign events_out = s_reg.ev;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence rise_pin1;
    $rose(lvl[1]) && $past(vld[1]) && vld[1] && s_reg.edge_select_reg_low[1] && !stop_mode_in;
  endsequence

  sequence fall_pin6;
    $fell(lvl[6]) && $past(vld[6]) && !s_reg.edge_select_reg_high[2] && !stop_mode_in;
  endsequence

  sequence baud_edge;
    $changed(lvl[ped_pkg::BAUD_PIN]) && $past(vld[ped_pkg::BAUD_PIN]) && baud_mode_in && !stop_mode_in;
  endsequence

  sequence pin0_rise_in_stop;
    stop_mode_in && $rose(lvl[0]) && $past(vld[0]) && s_reg.edge_select_reg_low[0];
  endsequence

  sequence rise_pin2;
    $rose(lvl[2]) && $past(vld[2]) && s_reg.edge_select_reg_low[2] && !stop_mode_in;
  endsequence

  sequence fall_pin2;
    $fell(lvl[2]) && $past(vld[2]) && !s_reg.edge_select_reg_low[2] && !stop_mode_in;
  endsequence

  sequence rise_pin3;
    $rose(lvl[3]) && $past(vld[3]) && s_reg.edge_select_reg_low[3] && !stop_mode_in;
  endsequence

  sequence rise_pin4;
    $rose(lvl[4]) && $past(vld[4]) && s_reg.edge_select_reg_high[0] && !stop_mode_in;
  endsequence

  sequence prime_pin1;
    $rose(vld[1]);
  endsequence

  reset_clears_a: assert property (@(posedge clk_sys_in) disable iff (1'b0)
    sys_rst_in |=> (edge_select_low_out == 8'h00 && edge_select_high_out == 8'h00))
    else $error("select registers not cleared by reset");

  byte_write_a: assert property ((reg_req_in.byte_wr && !reg_req_in.sel_high)
    |=> edge_select_low_out == ($past(reg_req_in.wr_data) & ped_pkg::SEL_MASK))
    else $error("byte write to low register lost");

  bit_write_a: assert property ((reg_req_in.bit_wr && !reg_req_in.byte_wr &&
    reg_req_in.sel_high && reg_req_in.bit_idx < 3'h4)
    |=> edge_select_high_out[$past(reg_req_in.bit_idx)] == $past(reg_req_in.bit_val))
    else $error("bit write to high register lost");

  tick_period_a: assert property (tick |=> (!tick)[*3] ##1 tick)
    else $error("sample tick not every four clocks");

  rise_detect_a: assert property (rise_pin1 |=> events_out.ext_irq_zero &&
    events_out.timer1_capture && events_out.rto_trigger)
    else $error("selected rising edge on pin one not forwarded");

  fall_detect_a: assert property (fall_pin6 |=> events_out.ext_irq_five && events_out.adc_start)
    else $error("selected falling edge on pin six not forwarded");

  pulse_single_a: assert property (events_out.ext_irq_zero |=> !events_out.ext_irq_zero)
    else $error("edge pulse longer than one clock");

  stop_quiet_a: assert property (stop_mode_in |=> !(events_out.ext_irq_zero ||
    events_out.ext_irq_three || events_out.ext_irq_five || events_out.uart_baud_clock))
    else $error("filtered pin edge reported in stop mode");

  pin0_stop_a: assert property (pin0_rise_in_stop |=> events_out.nmi && events_out.standby_wake)
    else $error("pin zero edge lost in stop mode");

  baud_both_a: assert property (baud_edge |=> events_out.uart_baud_clock)
    else $error("baud clock edge not detected");

  slot4_timer_a: assert property (s_reg.edge_select_reg_high[ped_pkg::SLOT4_SEL_BIT]
    |=> events_out.irq_slot_four == $past(timer3_match_irq_in))
    else $error("slot four does not follow timer match");

  slot4_pin_a: assert property (!s_reg.edge_select_reg_high[ped_pkg::SLOT4_SEL_BIT]
    |=> events_out.irq_slot_four == events_out.ext_irq_four)
    else $error("slot four does not follow pin interrupt");

  raw_read_a: assert property ((!$past(sys_rst_in) && !$past(sys_rst_in, 2))
    |-> raw_pins_out == $past(edge_pins_in, 2))
    else $error("raw pin levels not two clocks behind pins");

  pin2_rise_a: assert property (rise_pin2 |=> events_out.ext_irq_one && events_out.timer2_capture)
    else $error("selected rising edge on pin two not forwarded");

  pin2_fall_a: assert property (fall_pin2 |=> events_out.ext_irq_one && events_out.timer2_capture)
    else $error("selected falling edge on pin two not forwarded");

  pin3_route_a: assert property (rise_pin3
    |=> events_out.ext_irq_two && events_out.timer2_count_clock)
    else $error("pin three edge not routed");

  pin4_route_a: assert property (rise_pin4
    |=> events_out.ext_irq_three && events_out.timer16_capture)
    else $error("pin four edge not routed");

  wrong_pol_a: assert property (($rose(lvl[2]) && !s_reg.edge_select_reg_low[2])
    |=> !events_out.ext_irq_one)
    else $error("rising edge on pin two forwarded while falling selected");

  pin0_fall_a: assert property (($fell(lvl[0]) && $past(vld[0]) && !s_reg.edge_select_reg_low[0])
    |=> events_out.nmi && events_out.standby_wake)
    else $error("selected falling edge on pin zero not forwarded");

  nmi_single_a: assert property (events_out.nmi |=> !events_out.nmi)
    else $error("pin zero edge pulse longer than one clock");

  pin1_pairs_a: assert property (events_out.ext_irq_zero
    |-> events_out.timer1_capture && events_out.rto_trigger)
    else $error("pin one edge not sent to capture and trigger");

  pin6_pairs_a: assert property (events_out.ext_irq_five |-> events_out.adc_start)
    else $error("pin six edge not sent to converter start");

  stop_rest_a: assert property (stop_mode_in |=> !(events_out.ext_irq_one || events_out.ext_irq_two ||
    events_out.ext_irq_four || events_out.timer16_capture))
    else $error("pin two to five edge reported in stop mode");

  prime_quiet_a: assert property (prime_pin1 |=> !events_out.ext_irq_zero)
    else $error("edge reported on first accepted level after reset");

  reserved_zero_a: assert property (edge_select_low_out[7:4] == 4'h0 &&
    edge_select_high_out[7:4] == 4'h0)
    else $error("reserved select bits not zero");

  byte_high_a: assert property ((reg_req_in.byte_wr && reg_req_in.sel_high)
    |=> edge_select_high_out == ($past(reg_req_in.wr_data) & ped_pkg::SEL_MASK))
    else $error("byte write to high register lost");

  bit_low_a: assert property ((reg_req_in.bit_wr && !reg_req_in.byte_wr &&
    !reg_req_in.sel_high && reg_req_in.bit_idx < 3'h4)
    |=> edge_select_low_out[$past(reg_req_in.bit_idx)] == $past(reg_req_in.bit_val))
    else $error("bit write to low register lost");

  baud_gate_a: assert property (!baud_mode_in |=> !events_out.uart_baud_clock)
    else $error("baud clock pulse without baud mode");

endmodule

// *** tb/ped_pin_src.sv ***
// pin source model driving the seven edge pins
`timescale 1ns/1ps
module ped_pin_src (
  input  logic       clk_sys_in,
  output logic [6:0] pins_out
);
  initial pins_out = 7'h00;

  // level changes just after an edge and is held for n cycles
  task automatic drive(input int k, input logic v, input int n);
    @(posedge clk_sys_in);
    #1;
    pins_out[k] = v;
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
endmodule

// *** tb/ped_top_tb.sv ***
// self-checking testbench for the pin edge detection unit
`timescale 1ns/1ps
module ped_top_tb;
  logic                  clk_sys_in;
  logic                  sys_rst_in;
  logic [6:0]            pins;
  logic                  stop_mode;
  logic                  baud_mode;
  logic                  t3_match;
  ped_pkg::ped_reg_req_t req;
  logic [7:0]            sel_lo;
  logic [7:0]            sel_hi;
  logic [6:0]            raw;
  ped_pkg::ped_events_t  ev;
  logic [15:0]           ev_bits;
  logic [15:0]           pin_mask [7];
  int                    mismatches;
  int                    checked;

  assign ev_bits = ev;

  ped_pin_src i_ped_pin_src (
    .clk_sys_in (clk_sys_in),
    .pins_out   (pins)
  );

  ped_top i_ped_top (
    .clk_sys_in           (clk_sys_in),
    .sys_rst_in           (sys_rst_in),
    .edge_pins_in         (pins),
    .stop_mode_in         (stop_mode),
    .baud_mode_in         (baud_mode),
    .timer3_match_irq_in  (t3_match),
    .reg_req_in           (req),
    .edge_select_low_out  (sel_lo),
    .edge_select_high_out (sel_hi),
    .raw_pins_out         (raw),
    .events_out           (ev)
  );

  initial clk_sys_in = 1'b0;
  always #12.5 clk_sys_in = ~clk_sys_in;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // byte write when bytew, else bit write of d[0] at idx
  task automatic wreg(input logic hi, input logic bytew, input logic [2:0] idx, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    req = '{sel_high: hi, byte_wr: bytew, bit_wr: !bytew, bit_idx: idx, bit_val: d[0], wr_data: d};
    @(posedge clk_sys_in);
    #1;
    req.byte_wr = 1'b0;
    req.bit_wr = 1'b0;
  endtask

  // collects events over n cycles, checks them and the first-pulse cycle
  task automatic wait_ev(input int n, input int lo, input int hi, input logic [15:0] exp);
    logic [15:0] acc;
    int          first;
    acc = 16'h0000;
    first = 0;
    for (int i = 1; i <= n; i++)
    begin
      @(posedge clk_sys_in);
      #1;
      if (ev_bits != 16'h0000 && first == 0)
        first = i;
      acc |= ev_bits;
    end
    chk(acc, exp);
    if (exp != 16'h0000)
      chk({15'h0000, first >= lo && first <= hi}, 16'h0001);
  endtask

  initial
  begin
    sys_rst_in = 1'b1;
    stop_mode = 1'b0;
    baud_mode = 1'b0;
    t3_match = 1'b0;
    req = '0;
    mismatches = 0;
    checked = 0;
    pin_mask = '{16'hC000, 16'h3800, 16'h0600, 16'h0180, 16'h0060, 16'h0011, 16'h0006};
    repeat (6) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    chk({8'h00, sel_lo}, 16'h0000);
    chk({8'h00, sel_hi}, 16'h0000);
    chk(ev_bits, 16'h0000);
    $display("test reset done");
    wreg(1'b0, 1'b1, 3'h0, 8'hFF);
    chk({8'h00, sel_lo}, 16'h000F);
    wreg(1'b1, 1'b1, 3'h0, 8'hF7);
    chk({8'h00, sel_hi}, 16'h0007);
    wreg(1'b1, 1'b0, 3'h5, 8'h01);
    chk({8'h00, sel_hi}, 16'h0007);
    wreg(1'b1, 1'b0, 3'h3, 8'h01);
    chk({8'h00, sel_hi}, 16'h000F);
    wreg(1'b1, 1'b0, 3'h3, 8'h00);
    chk({8'h00, sel_hi}, 16'h0007);
    $display("test registers done");
    repeat (420) @(posedge clk_sys_in);
    i_ped_pin_src.drive(3, 1'b1, 3);
    chk({9'h000, raw}, 16'h0008);
    i_ped_pin_src.drive(3, 1'b0, 0);
    wait_ev(24, 0, 0, 16'h0000);
    i_ped_pin_src.drive(3, 1'b1, 7);
    i_ped_pin_src.drive(3, 1'b0, 0);
    wait_ev(24, 0, 0, 16'h0000);
    $display("test glitch done");
    for (int k = 1; k < 7; k++)
    begin
      i_ped_pin_src.drive(k, 1'b1, 0);
      wait_ev(24, 8, 16, pin_mask[k]);
      i_ped_pin_src.drive(k, 1'b0, 0);
      wait_ev(24, 0, 0, 16'h0000);
    end
    wreg(1'b0, 1'b0, 3'h2, 8'h00);
    i_ped_pin_src.drive(2, 1'b1, 0);
    wait_ev(24, 0, 0, 16'h0000);
    i_ped_pin_src.drive(2, 1'b0, 0);
    wait_ev(24, 8, 16, 16'h0600);
    i_ped_pin_src.drive(0, 1'b1, 0);
    wait_ev(420, 400, 406, 16'hC000);
    $display("test edges done");
    stop_mode = 1'b1;
    i_ped_pin_src.drive(1, 1'b1, 0);
    wait_ev(24, 0, 0, 16'h0000);
    wreg(1'b0, 1'b0, 3'h0, 8'h00);
    i_ped_pin_src.drive(0, 1'b0, 0);
    wait_ev(420, 400, 406, 16'hC000);
    stop_mode = 1'b0;
    i_ped_pin_src.drive(1, 1'b0, 0);
    wait_ev(24, 0, 0, 16'h0000);
    $display("test stop done");
    baud_mode = 1'b1;
    i_ped_pin_src.drive(5, 1'b1, 0);
    wait_ev(24, 8, 16, 16'h0019);
    i_ped_pin_src.drive(5, 1'b0, 0);
    wait_ev(24, 8, 16, 16'h0008);
    baud_mode = 1'b0;
    wreg(1'b1, 1'b0, 3'h3, 8'h01);
    @(posedge clk_sys_in);
    #1;
    t3_match = 1'b1;
    @(posedge clk_sys_in);
    #1;
    t3_match = 1'b0;
    chk(ev_bits, 16'h0001);
    i_ped_pin_src.drive(5, 1'b1, 0);
    wait_ev(24, 8, 16, 16'h0010);
    $display("test slot four done");
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    chk({sel_hi, sel_lo}, 16'h0000);
    chk(ev_bits, 16'h0000);
    $display("test mid reset done");
    test_done();
  end

  initial
  begin
    repeat (12000) @(posedge clk_sys_in);
    mismatches++;
    test_done();
  end
endmodule
